// file: rtl/oamx_decode.sv
// Purpose: splits one instruction word into class, destination, address, literal
// Assumes: word is stable for the whole cycle it is presented
// Notes: purely combinational, no state
module oamx_decode
  import oamx_pkg::*;
(
  input wire logic [OAMX_IW-1:0] instr_i,
  output oamx_dec_t dec_o
);

  // ----------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------
  // fields are always extracted; only the class says which ones matter
  always_comb begin
    dec_o.op = oamx_op_of(instr_i);
    dec_o.dest = instr_i[OAMX_DEST_BIT];
    dec_o.addr = instr_i[OAMX_AW-1:0];
    dec_o.lit = instr_i[OAMX_DW-1:0];
  end

endmodule : oamx_decode

// file: rtl/oamx_exec.sv
// Purpose: executes or-with-file, load-literal, copy-file and store-working
// Assumes: file_data_i holds the file register addressed by instr_i[6:0] in the
//   same cycle; one word may be offered every cycle
// Notes: results and write strobes appear one cycle after the word is taken
module oamx_exec
  import oamx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [OAMX_IW-1:0] instr_i,
  input wire logic [OAMX_DW-1:0] file_data_i,
  output logic [OAMX_DW-1:0] w_o,
  output logic zero_o,
  output logic file_we_o,
  output logic [OAMX_AW-1:0] file_addr_o,
  output logic [OAMX_DW-1:0] file_wdata_o,
  output logic done_o,
  output logic unknown_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  oamx_dec_t dec;
  oamx_state_t st_r;
  oamx_state_t st_nxt;

  oamx_decode u_decode (
    .instr_i(instr_i),
    .dec_o(dec)
  );

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  // one pass per word: no multi-cycle path, so nothing can stall the fetch
  // a word that writes back its own source is seen by the next word only
  // through the partner's forwarding; this block holds no copy of the file
  always_comb begin
    logic [OAMX_DW-1:0] res;
    res = '0;
    st_nxt = st_r;
    st_nxt.file_we = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.unknown = 1'b0;
    if (instr_valid_i) begin
      unique case (dec.op)
        OAMX_OP_OR: begin
          res = st_r.w | file_data_i;
          st_nxt.z = (res == '0);
          if (dec.dest) begin
            st_nxt.file_we = 1'b1;
            st_nxt.file_addr = dec.addr;
            st_nxt.file_wdata = res;
          end else begin
            st_nxt.w = res;
          end
          st_nxt.done = 1'b1;
        end
        OAMX_OP_LIT: begin
          st_nxt.w = dec.lit; // flags untouched
          st_nxt.done = 1'b1;
        end
        OAMX_OP_COPY: begin
          res = file_data_i;
          st_nxt.z = (res == '0); // also when written back
          if (dec.dest) begin
            st_nxt.file_we = 1'b1;
            st_nxt.file_addr = dec.addr;
            st_nxt.file_wdata = res;
          end else begin
            st_nxt.w = res;
          end
          st_nxt.done = 1'b1;
        end
        OAMX_OP_STORE: begin
          st_nxt.file_we = 1'b1; // no flag change
          st_nxt.file_addr = dec.addr;
          st_nxt.file_wdata = st_r.w;
          st_nxt.done = 1'b1;
        end
        OAMX_OP_NONE: begin
          // other opcodes belong to other units; flag them and change nothing
          st_nxt.unknown = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset; address and data are cleared so outputs are defined
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r.w <= OAMX_W_RST;
      st_r.z <= OAMX_Z_RST;
      st_r.file_we <= 1'b0;
      st_r.file_addr <= '0;
      st_r.file_wdata <= '0;
      st_r.done <= 1'b0;
      st_r.unknown <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------
  assign w_o = st_r.w;
  assign zero_o = st_r.z;
  assign file_we_o = st_r.file_we;
  assign file_addr_o = st_r.file_addr;
  assign file_wdata_o = st_r.file_wdata;
  assign done_o = st_r.done;
  assign unknown_o = st_r.unknown;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // independent decode of the four classes from the raw word bits, so a
  // broken decoder cannot hide behind its own output
  logic word_known;
  assign word_known = (instr_i[13:8] == OAMX_OPC_OR) || (instr_i[13:8] == OAMX_OPC_COPY)
      || (instr_i[13:10] == OAMX_OPC_LIT) || (instr_i[13:7] == OAMX_OPC_STORE);

  // or result to working register, file untouched
  a_or_to_w: assert property (
    instr_valid_i && instr_i[13:8] == OAMX_OPC_OR && !instr_i[OAMX_DEST_BIT]
    |=> w_o == ($past(w_o) | $past(file_data_i)) && !file_we_o
  ) else $error("or to working register wrong");

  // or result back to file register, working register kept
  a_or_to_file: assert property (
    instr_valid_i && instr_i[13:8] == OAMX_OPC_OR && instr_i[OAMX_DEST_BIT]
    |=> file_we_o && file_addr_o == $past(instr_i[6:0])
        && file_wdata_o == ($past(w_o) | $past(file_data_i)) && $stable(w_o)
  ) else $error("or to file register wrong");

  // zero flag after or follows the or result
  a_or_zero_flag: assert property (
    instr_valid_i && instr_i[13:8] == OAMX_OPC_OR
    |=> zero_o == (($past(w_o) | $past(file_data_i)) == 8'h00)
  ) else $error("zero flag after or wrong");

  // literal load regardless of don't-care bits, flags unchanged
  a_lit_load_w: assert property (
    instr_valid_i && instr_i[13:10] == OAMX_OPC_LIT
    |=> w_o == $past(instr_i[7:0]) && !file_we_o
  ) else $error("literal not loaded");

  a_lit_keeps_zero: assert property (
    instr_valid_i && instr_i[13:10] == OAMX_OPC_LIT |=> $stable(zero_o)
  ) else $error("literal load changed zero flag");

  // copy to working register or back to its source
  a_copy_dest: assert property (
    instr_valid_i && instr_i[13:8] == OAMX_OPC_COPY
    |=> ($past(instr_i[OAMX_DEST_BIT])
         ? (file_we_o && file_wdata_o == $past(file_data_i)
            && file_addr_o == $past(instr_i[6:0]) && $stable(w_o))
         : (!file_we_o && w_o == $past(file_data_i)))
  ) else $error("copy destination wrong");

  // zero flag set by copy in both destinations
  a_copy_zero_flag: assert property (
    instr_valid_i && instr_i[13:8] == OAMX_OPC_COPY
    |=> zero_o == ($past(file_data_i) == 8'h00)
  ) else $error("zero flag after copy wrong");

  // store writes working register, flags and working register kept
  a_store_write: assert property (
    instr_valid_i && instr_i[13:7] == OAMX_OPC_STORE
    |=> file_we_o && file_wdata_o == $past(w_o)
        && file_addr_o == $past(instr_i[6:0]) && $stable(zero_o) && $stable(w_o)
  ) else $error("store working register wrong");

  // every known word retires exactly one cycle later, back to back
  a_one_cycle_done: assert property (
    instr_valid_i ##1 instr_valid_i
    |-> (done_o == $past(word_known)) ##1 (done_o == $past(word_known))
  ) else $error("instruction did not retire in one cycle");

  // file write strobe lasts one cycle unless a new word asks for it
  a_we_one_pulse: assert property (
    !instr_valid_i |=> !file_we_o && !done_o && !unknown_o
  ) else $error("write strobe or retire pulse without a word");

  // an idle cycle leaves working register, zero flag and write target alone
  a_idle_keeps_state: assert property (
    !instr_valid_i |=> $stable(w_o) && $stable(zero_o)
        && $stable(file_addr_o) && $stable(file_wdata_o)
  ) else $error("idle cycle changed state");

  // a known word always retires the next cycle, never flagged as foreign
  a_known_retires: assert property (
    instr_valid_i && word_known |=> done_o && !unknown_o
  ) else $error("known word did not retire");

  // toolchains leave the don't-care bits at zero; set ones must still load
  a_lit_dc_set: assert property (
    instr_valid_i && instr_i[13:10] == OAMX_OPC_LIT && instr_i[9:8] != 2'b00
    |=> done_o && w_o == $past(instr_i[7:0])
  ) else $error("literal with don't-care bits set not loaded");

  // a foreign word pulses unknown and leaves every result untouched
  a_unknown_no_effect: assert property (
    instr_valid_i && !word_known
    |=> unknown_o && !done_o && !file_we_o && $stable(w_o) && $stable(zero_o)
  ) else $error("foreign word changed state");

  // reset wins over any word; watched while reset is low, so never disabled
  a_reset_clears: assert property (
    disable iff (1'b0)
    !rst_n_i |=> w_o == OAMX_W_RST && zero_o == OAMX_Z_RST && !file_we_o
        && file_addr_o == '0 && file_wdata_o == '0 && !done_o && !unknown_o
  ) else $error("reset values wrong");

endmodule : oamx_exec

// file: rtl/oamx_pkg.sv
// Purpose: constants and types shared by the four-instruction execute block
// Assumes: 14-bit instruction word, 8-bit data path, 7-bit direct file address
// Notes: How it works list follows
// How it works
// - an or-with-file word ORs the working register with the addressed file register and sets zero from the result.
// - for or-with-file, destination bit 0 sends the result to the working register and 1 sends it back to the file register.
// - a load-literal word puts its 8-bit immediate into the working register and leaves every flag alone.
// - load-literal is recognised whatever its two don't-care bits hold.
// - a copy-file word sends the file register's value to the working register (bit 0) or back to itself (bit 1).
// - copy-file sets zero from the copied value even when it writes back to its source.
// - a store-working word writes the working register into the addressed file register and touches no flag.
package oamx_pkg;

  // ----------------------------------------------------------------
  // field layout of the instruction word
  // ----------------------------------------------------------------
  localparam int OAMX_IW = 14;
  localparam int OAMX_DW = 8;
  localparam int OAMX_AW = 7;
  localparam int OAMX_DEST_BIT = 7;

  // ----------------------------------------------------------------
  // opcode patterns, compared against the top bits only
  // ----------------------------------------------------------------
  localparam logic [5:0] OAMX_OPC_OR = 6'h04;
  localparam logic [5:0] OAMX_OPC_COPY = 6'h08;
  localparam logic [3:0] OAMX_OPC_LIT = 4'hC;
  localparam logic [6:0] OAMX_OPC_STORE = 7'h01;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] OAMX_W_RST = 8'h00;
  localparam logic OAMX_Z_RST = 1'b0;

  typedef enum logic [2:0] {
    OAMX_OP_NONE,
    OAMX_OP_OR,
    OAMX_OP_LIT,
    OAMX_OP_COPY,
    OAMX_OP_STORE
  } oamx_op_t;

  typedef struct packed {
    oamx_op_t op;
    logic dest;
    logic [OAMX_AW-1:0] addr;
    logic [OAMX_DW-1:0] lit;
  } oamx_dec_t;

  typedef struct packed {
    logic [OAMX_DW-1:0] w;
    logic z;
    logic file_we;
    logic [OAMX_AW-1:0] file_addr;
    logic [OAMX_DW-1:0] file_wdata;
    logic done;
    logic unknown;
  } oamx_state_t;

  // opcode class of one word; the don't-care bits of load-literal are ignored
  function automatic oamx_op_t oamx_op_of(input logic [OAMX_IW-1:0] iw);
    oamx_op_t op;
    op = OAMX_OP_NONE;
    if (iw[13:8] == OAMX_OPC_OR) begin
      op = OAMX_OP_OR;
    end else if (iw[13:8] == OAMX_OPC_COPY) begin
      op = OAMX_OP_COPY;
    end else if (iw[13:10] == OAMX_OPC_LIT) begin
      op = OAMX_OP_LIT;
    end else if (iw[13:7] == OAMX_OPC_STORE) begin
      op = OAMX_OP_STORE;
    end
    return op;
  endfunction : oamx_op_of

endpackage : oamx_pkg

// file: verification/oamx_regfile_model.sv
// Purpose: behavioural file register bank beside the execute block
// Assumes: 128 bytes, read is combinational on the word's address field
// Notes: a write retires one cycle late, so the read forwards it
module oamx_regfile_model
  import oamx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [OAMX_AW-1:0] rd_addr_i,
  input wire logic we_i,
  input wire logic [OAMX_AW-1:0] waddr_i,
  input wire logic [OAMX_DW-1:0] wdata_i,
  output logic [OAMX_DW-1:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [OAMX_DW-1:0] mem [128];

  // all bytes start at zero so the bench shadow can match them
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // write port driven by the block's strobe
  always @(posedge mclk_i) begin
    if (we_i) mem[waddr_i] <= wdata_i;
  end

  // forwarding hides the write landing on the same edge as the next read
  assign rd_data_o = (we_i && waddr_i == rd_addr_i) ? wdata_i : mem[rd_addr_i];
endmodule : oamx_regfile_model

// file: verification/tb.sv
// Purpose: self-checking bench for the four-instruction execute block
// Assumes: one word per cycle, results one cycle after the word is taken
// Notes: expectations come from a shadow of w, zero and the file bank
module tb import oamx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, vld = 0, z, we, done, unk;
  logic [13:0] iw = 14'h0000;
  logic [7:0] fdata, w, fwd;
  logic [6:0] fa;
  logic [7:0] ew = 8'h00, ewd = 8'h00, sh [128];
  logic ez = 0, ewe = 0;
  logic [6:0] ea = 7'h00;
  int fail_count = 0, n_tests = 0;

  initial begin
    forever #4 mclk = ~mclk;
  end

  oamx_exec dut (.mclk_i(mclk), .rst_n_i(rst_n), .instr_valid_i(vld), .instr_i(iw),
    .file_data_i(fdata), .w_o(w), .zero_o(z), .file_we_o(we), .file_addr_o(fa),
    .file_wdata_o(fwd), .done_o(done), .unknown_o(unk));
  oamx_regfile_model p (.mclk_i(mclk), .rd_addr_i(iw[6:0]), .we_i(we), .waddr_i(fa),
    .wdata_i(fwd), .rd_data_o(fdata));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // drive one word at the falling edge, predict, judge one cycle later
  task step(input logic [13:0] i);
    logic [7:0] r;
    logic d, isun;
    d = i[7];
    r = ew;
    isun = 0;
    vld = 1;
    iw = i;
    if (i[13:8] == 6'h04) begin
      r = ew | sh[i[6:0]];
      ez = (r == 8'h00);
    end else if (i[13:8] == 6'h08) begin
      r = sh[i[6:0]];
      ez = (r == 8'h00);
    end else if (i[13:10] == 4'hC) begin
      r = i[7:0];
      d = 0;
    end else if (i[13:7] == 7'h01) begin
      d = 1;
    end else isun = 1;
    ewe = !isun && d;
    if (ewe) begin
      ea = i[6:0];
      ewd = r;
      sh[i[6:0]] = r;
    end else if (!isun) ew = r;
    @(posedge mclk);
    @(negedge mclk);
    check(done, !isun);
    check(unk, isun);
    check(w, ew);
    check(z, ez);
    check(we, ewe);
    check({fa, fwd}, {ea, ewd});
  endtask : step

  // seed a file byte through the block itself
  task poke(input logic [6:0] a, input logic [7:0] v);
    step({6'h30, v});
    step({7'h01, a});
  endtask : poke

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_lit;
    step({6'h08, 1'b0, 7'h10});
    for (int k = 0; k < 4; k++) step({4'hC, k[1:0], 8'h5A + k[7:0]});
    $display("test lit done");
  endtask : t_lit

  task t_or;
    poke(7'h20, 8'h13);
    step({6'h30, 8'h91});
    step({6'h04, 1'b0, 7'h20});
    step({6'h30, 8'h00});
    step({6'h04, 1'b0, 7'h21});
    step({6'h30, 8'h40});
    step({6'h04, 1'b1, 7'h20});
    step({6'h08, 1'b0, 7'h20});
    $display("test or done");
  endtask : t_or

  task t_copy;
    step({6'h08, 1'b1, 7'h21});
    step({6'h08, 1'b1, 7'h20});
    step({6'h08, 1'b0, 7'h7F});
    $display("test copy done");
  endtask : t_copy

  task t_store;
    step({6'h04, 1'b0, 7'h21});
    step({6'h30, 8'hA5});
    step({7'h01, 7'h7F});
    step({7'h01, 7'h00});
    step({6'h08, 1'b0, 7'h7F});
    $display("test store done");
  endtask : t_store

  // words outside the four and idle cycles must leave everything alone
  task t_misc;
    step(14'h3800);
    step(14'h0000);
    step(14'h0064);
    vld = 0;
    @(posedge mclk);
    @(negedge mclk);
    check({done, we, unk, w, z}, {3'h0, ew, ez});
    $display("test misc done");
  endtask : t_misc

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (20) @(negedge mclk);
    check({w, z, we, fa, fwd, done, unk}, 27'h0000000);
    rst_n = 1;
    t_lit();
    t_or();
    t_copy();
    t_store();
    t_misc();
    give_verdict();
  end
endmodule : tb
